// >>> tct_timer.sv
// Purpose: Sixteen-bit timer/counter with byte register port, overflow interrupt and trigger reset.
// Assumes: Each system clock cycle is one instruction cycle; trigger input is on the same clock.
// Notes:   External pins are always passed through two flip-flops before use.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "tct_defines.svh"
module tct_timer
(
    input  wire logic                ref_clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    input  wire tct_pkg::tct_addr_t  addr_i,
    input  wire tct_pkg::tct_byte_t  wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output tct_pkg::tct_byte_t       rdata_o,
    input  wire logic                ext_clk_pin_i,
    input  wire logic                neighbour_osc_i,
    input  wire logic                neighbour_osc_enable_i,
    input  wire logic                ccp_trigger_i,
    output tct_pkg::tct_count_t      count_o,
    output logic [1:0]               ccp_timebase_sel_o,
    output logic                     ccp_timebase_o,
    output logic                     irq_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    tct_pkg::tct_byte_t  ctrl_r;
    tct_pkg::tct_count_t cnt_r;
    tct_pkg::tct_byte_t  hi_buf_r;
    tct_pkg::tct_byte_t  rdata_r;
    logic                overflow_flag_r;
    logic                overflow_flag_nxt;
    logic                overflow_irq_enable_r;
    logic                overflow_irq_enable_nxt;
    logic                irq_r;
    logic [1:0]          pin_meta_r;
    logic [1:0]          pin_sync_r;
    logic                src_prev_r;
    logic                edge_q_r;

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic                wide_access_mode;
    logic                counter_run;
    logic                count_source_select;
    logic                ext_input_sync_n;
    tct_pkg::tct_prescale_e ps_sel;
    logic                wr_ctrl;
    logic                wr_low;
    logic                wr_high;
    logic                wr_status;
    logic                wr_mask;
    logic                rd_low;
    logic                cnt_write;
    logic                src_level;
    logic                src_edge;
    logic                ext_tick;
    logic                raw_tick;
    logic                ps_tick;
    logic                inc;
    logic                wrap;

    assign wide_access_mode    = ctrl_r[`TCT_BIT_WIDE];
    assign counter_run         = ctrl_r[`TCT_BIT_RUN];
    assign count_source_select = ctrl_r[`TCT_BIT_SRC];
    assign ext_input_sync_n    = ctrl_r[`TCT_BIT_SYNC_N];
    assign ps_sel              = tct_pkg::tct_prescale_e'(ctrl_r[`TCT_BIT_PS_HI:`TCT_BIT_PS_LO]);

    assign wr_ctrl   = wr_i && (addr_i == `TCT_OFF_CTRL);
    assign wr_low    = wr_i && (addr_i == `TCT_OFF_LOW);
    assign wr_high   = wr_i && (addr_i == `TCT_OFF_HIGH);
    assign wr_status = wr_i && (addr_i == `TCT_OFF_STATUS);
    assign wr_mask   = wr_i && (addr_i == `TCT_OFF_MASK);
    assign rd_low    = rd_i && (addr_i == `TCT_OFF_LOW);

    // In wide mode a high-byte write only fills the buffer, so the count moves on the low write.
    assign cnt_write = wr_low || (wr_high && !wide_access_mode); // RULE_15

    // ****************************************************************
    // Count source
    // ****************************************************************
    // Both pins are synchronised unconditionally; the unsynchronised mode only drops
    // the extra alignment stage, since a raw pin may never reach the logic here.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            pin_meta_r <= 2'h0;
            pin_sync_r <= 2'h0;
            src_prev_r <= 1'b0;
            edge_q_r   <= 1'b0;
        end
        else if (ce_i)
        begin
            pin_meta_r <= {neighbour_osc_i, ext_clk_pin_i};
            pin_sync_r <= pin_meta_r;
            src_prev_r <= src_level;
            edge_q_r   <= src_edge;
        end
    end

    assign src_level = neighbour_osc_enable_i ? pin_sync_r[1] : pin_sync_r[0]; // RULE_09
    assign src_edge  = src_level && !src_prev_r; // RULE_10
    assign ext_tick  = ext_input_sync_n ? src_edge : edge_q_r;
    // Internal source counts every cycle regardless of the synchronise bit.
    assign raw_tick  = counter_run && (count_source_select ? ext_tick : 1'b1); // RULE_05 RULE_08 RULE_10

    tct_prescaler u_prescaler
    (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .clear_i   (cnt_write || wr_ctrl),
        .tick_i    (raw_tick),
        .ps_i      (ps_sel),
        .tick_o    (ps_tick)
    );

    assign inc  = ps_tick && !cnt_write && !ccp_trigger_i; // RULE_14
    assign wrap = inc && (cnt_r == `TCT_COUNT_MAX); // RULE_03

    // ****************************************************************
    // Control register
    // ****************************************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            ctrl_r <= `TCT_CTRL_RST;
        end
        else if (ce_i && wr_ctrl)
        begin
            ctrl_r <= wdata_i; // RULE_07
        end
    end

    // ****************************************************************
    // Counter
    // ****************************************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            cnt_r <= `TCT_COUNT_RST;
        end
        else if (ce_i)
        begin
            if (wr_low && wide_access_mode)
            begin
                cnt_r <= {hi_buf_r, wdata_i}; // RULE_15 RULE_13
            end
            else if (wr_low)
            begin
                cnt_r[7:0] <= wdata_i; // RULE_02 RULE_13
            end
            else if (wr_high && !wide_access_mode)
            begin
                cnt_r[15:8] <= wdata_i; // RULE_02 RULE_13
            end
            else if (ccp_trigger_i)
            begin
                cnt_r <= `TCT_COUNT_RST; // RULE_04
            end
            else if (inc)
            begin
                cnt_r <= cnt_r + 16'h0001; // RULE_01
            end
        end
    end

    // ****************************************************************
    // High byte buffer
    // ****************************************************************
    // One buffer serves reads and writes, as the strobes never coincide.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            hi_buf_r <= 8'h00;
        end
        else if (ce_i && wide_access_mode)
        begin
            if (rd_low)
            begin
                hi_buf_r <= cnt_r[15:8]; // RULE_15
            end
            else if (wr_high)
            begin
                hi_buf_r <= wdata_i; // RULE_15
            end
        end
    end

    // ****************************************************************
    // Interrupt
    // ****************************************************************
    // A wrap in the clearing cycle keeps the flag set.
    assign overflow_flag_nxt = wrap || (overflow_flag_r && !(wr_status && wdata_i[`TCT_BIT_OVF])); // RULE_11 RULE_12
    assign overflow_irq_enable_nxt = wr_mask ? wdata_i[`TCT_BIT_OVF] : overflow_irq_enable_r;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            overflow_flag_r       <= 1'b0;
            overflow_irq_enable_r <= 1'b0;
            irq_r                 <= 1'b0;
        end
        else if (ce_i)
        begin
            overflow_flag_r       <= overflow_flag_nxt; // RULE_03
            overflow_irq_enable_r <= overflow_irq_enable_nxt;
            irq_r                 <= overflow_flag_nxt && overflow_irq_enable_nxt; // RULE_11
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            rdata_r <= 8'h00;
        end
        else if (ce_i)
        begin
            rdata_r <= 8'h00;
            if (rd_i)
            begin
                unique case (addr_i)
                    `TCT_OFF_CTRL:   rdata_r <= ctrl_r;
                    `TCT_OFF_LOW:    rdata_r <= cnt_r[7:0]; // RULE_02
                    `TCT_OFF_HIGH:   rdata_r <= wide_access_mode ? hi_buf_r : cnt_r[15:8]; // RULE_02 RULE_15
                    `TCT_OFF_STATUS: rdata_r <= {7'h00, overflow_flag_r};
                    `TCT_OFF_MASK:   rdata_r <= {7'h00, overflow_irq_enable_r};
                    default:         rdata_r <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rdata_o            = rdata_r;
    assign count_o            = cnt_r;
    assign ccp_timebase_sel_o = {ctrl_r[`TCT_BIT_TB_HI], ctrl_r[`TCT_BIT_TB_LO]}; // RULE_07
    assign ccp_timebase_o     = ctrl_r[`TCT_BIT_TB_HI]; // RULE_06
    assign irq_o              = irq_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk_i iff ce_i);
    endclocking
    default disable iff (rst_i);

    AST_WRAP_TO_ZERO: // RULE_03
        assert property (wrap |=> (cnt_r == 16'h0000) && overflow_flag_r)
        else $error("count did not wrap to zero with overflow flag");

    AST_TRIGGER_CLEARS: // RULE_04
        assert property ((ccp_trigger_i && !cnt_write) |=> (cnt_r == 16'h0000))
        else $error("trigger did not clear the count");

    AST_WRITE_BEATS_TRIGGER: // RULE_13
        assert property ((wr_low && ccp_trigger_i && !wide_access_mode) |=> (cnt_r[7:0] == $past(wdata_i)))
        else $error("trigger overrode a software write");

    AST_TRIGGER_NO_FLAG: // RULE_12
        assert property ($rose(overflow_flag_r) |-> $past(wrap))
        else $error("overflow flag set without a wrap");

    AST_RUN_FREEZE: // RULE_14
        assert property ((!counter_run && !cnt_write && !ccp_trigger_i) |=> $stable(cnt_r))
        else $error("count moved while stopped");

    AST_INTERNAL_RATE: // RULE_10
        assert property ((counter_run && !count_source_select && !wr_ctrl && !cnt_write && !ccp_trigger_i
                          && ps_sel == tct_pkg::TCT_PS_DIV1)
                         |=> (cnt_r == $past(cnt_r) + 16'h0001))
        else $error("internal source did not count every cycle");

    AST_DIV8_SPACING: // RULE_14
        assert property ($changed(cnt_r) && counter_run && !count_source_select && ps_sel == tct_pkg::TCT_PS_DIV8
                         && !wr_ctrl && !wr_i && !ccp_trigger_i
                         |=> ($stable(cnt_r) || !$stable(ctrl_r) || $past(wr_i) || $past(ccp_trigger_i)) [*7])
        else $error("divide-by-eight prescaler counted too fast");

    AST_IRQ_GATED: // RULE_11
        assert property (irq_o == (overflow_flag_r && overflow_irq_enable_r))
        else $error("interrupt output does not follow flag and enable");

    AST_TIMEBASE: // RULE_06
        assert property (wr_ctrl |=> (ccp_timebase_o == $past(wdata_i[`TCT_BIT_TB_HI]))
                         && (ccp_timebase_sel_o == {$past(wdata_i[`TCT_BIT_TB_HI]), $past(wdata_i[`TCT_BIT_TB_LO])}))
        else $error("timebase outputs disagree with the written select field");

    AST_WIDE_READ_LATCH: // RULE_15
        assert property ((rd_low && wide_access_mode) |=> (hi_buf_r == $past(cnt_r[15:8])))
        else $error("wide low read did not latch the high byte");

    AST_READ_ONE_CYCLE: // RULE_02
        assert property (!rd_i |=> (rdata_o == 8'h00))
        else $error("read data present without a read");

    COV_WRAP:
        cover property (wrap ##1 irq_o);
    COV_TRIGGER:
        cover property (ccp_trigger_i && cnt_r != 16'h0000);
    COV_EXT_EDGE:
        cover property (count_source_select && ext_tick && counter_run);
    COV_WIDE_WRITE:
        cover property ((wr_high && wide_access_mode) ##[1:4] wr_low);

endmodule

// >>> tct_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the 16-bit timer/counter.
// Assumes: Byte-wide register port with a 3-bit word address.
// Notes:   Included by its bare name; definitions only.
//
// Behaviour
// [RULE_01] Sixteen-bit up-counter held in two bytes.
// [RULE_02] Both count bytes read, write loads count.
// [RULE_03] Wrap FFFF to 0000 raises overflow event.
// [RULE_04] Capture unit trigger clears count to zero.
// [RULE_05] Control bit selects internal or external clock.
// [RULE_06] Timebase select 1x makes this capture timebase.
// [RULE_07] Control register holds mode and timebase selection.
// [RULE_08] Internal source ignores the synchronise bit.
// [RULE_09] Neighbour oscillator usable as external count source.
// [RULE_10] Source 0 counts cycles, 1 rising edges.
// [RULE_11] Overflow latched in flag, enable gates interrupt.
// [RULE_12] Trigger reset never sets the overflow flag.
// [RULE_13] Software write beats a coincident trigger reset.
// [RULE_14] Prescale 1/2/4/8; run bit low freezes count.
// [RULE_15] Wide mode buffers high byte for atomic access.
`ifndef TCT_DEFINES_SVH
`define TCT_DEFINES_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define TCT_OFF_CTRL      3'h0
`define TCT_OFF_LOW       3'h1
`define TCT_OFF_HIGH      3'h2
`define TCT_OFF_STATUS    3'h3
`define TCT_OFF_MASK      3'h4

// ********************************************************************
// Control field positions
// ********************************************************************
`define TCT_BIT_WIDE      7
`define TCT_BIT_TB_HI     6
`define TCT_BIT_PS_HI     5
`define TCT_BIT_PS_LO     4
`define TCT_BIT_TB_LO     3
`define TCT_BIT_SYNC_N    2
`define TCT_BIT_SRC       1
`define TCT_BIT_RUN       0
`define TCT_BIT_OVF       0

// ********************************************************************
// Reset values and counts
// ********************************************************************
`define TCT_CTRL_RST      8'h00
`define TCT_COUNT_RST     16'h0000
`define TCT_COUNT_MAX     16'hffff

`endif

// >>> tct_pkg.sv
// Purpose: Types shared by the timer/counter modules.
// Assumes: Nothing beyond the defines header.
// Notes:   Used only with explicit package scope.
package tct_pkg;

    typedef logic [7:0]  tct_byte_t;
    typedef logic [15:0] tct_count_t;
    typedef logic [2:0]  tct_addr_t;

    typedef enum logic [1:0]
    {
        TCT_PS_DIV1 = 2'h0,
        TCT_PS_DIV2 = 2'h1,
        TCT_PS_DIV4 = 2'h2,
        TCT_PS_DIV8 = 2'h3
    } tct_prescale_e;

endpackage

// >>> tct_prescaler.sv
// Purpose: Input prescaler that passes one of every 1, 2, 4 or 8 count ticks.
// Assumes: Ticks are one-cycle pulses on the system clock.
// Notes:   Cleared by the parent on any write to the count or control.
`timescale 1ns/1ps
module tct_prescaler
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  clear_i,
    input  wire logic                  tick_i,
    input  wire tct_pkg::tct_prescale_e ps_i,
    output logic                       tick_o
);

    logic [2:0] div_r;
    logic [2:0] div_mask;
    logic       terminal;

    always_comb
    begin
        unique case (ps_i)
            tct_pkg::TCT_PS_DIV1: div_mask = 3'h0;
            tct_pkg::TCT_PS_DIV2: div_mask = 3'h1;
            tct_pkg::TCT_PS_DIV4: div_mask = 3'h3;
            tct_pkg::TCT_PS_DIV8: div_mask = 3'h7;
        endcase
    end

    assign terminal = ((div_r & div_mask) == div_mask);
    assign tick_o   = tick_i & terminal; // RULE_14

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            div_r <= 3'h0;
        end
        else if (ce_i)
        begin
            if (clear_i)
            begin
                div_r <= 3'h0;
            end
            else if (tick_i)
            begin
                div_r <= terminal ? 3'h0 : div_r + 3'h1; // RULE_14
            end
        end
    end

endmodule

// >>> tct_far_model.sv
// Purpose: Far-side model: capture/compare trigger source and external count clock source.
// Assumes: Requests come from the bench on the system clock, changed just after a rising edge.
// Notes:   The count wave has a half period of four cycles and stands low between bursts.
`timescale 1ns/1ps
module tct_far_model
(
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic trig_req_i,
    input  wire logic wave_en_i,
    input  wire logic osc_sel_i,
    output logic      ext_clk_pin_o,
    output logic      neighbour_osc_o,
    output logic      ccp_trigger_o
);
    logic [1:0] phase_r;
    logic       wave_r;
    logic       noise_r;

    // ********************************************************************
    // Trigger pulse
    // ********************************************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            ccp_trigger_o <= 1'b0;
        else
            ccp_trigger_o <= trig_req_i;
    end

    // ********************************************************************
    // Count wave
    // ********************************************************************
    // The unselected source toggles every cycle, so a wrong source choice shows as a wrong count.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || !wave_en_i)
        begin
            phase_r <= 2'h0;
            wave_r  <= 1'b0;
            noise_r <= 1'b0;
        end
        else
        begin
            phase_r <= phase_r + 2'h1;
            noise_r <= ~noise_r;
            if (phase_r == 2'h3)
                wave_r <= ~wave_r;
        end
    end

    assign ext_clk_pin_o   = osc_sel_i ? noise_r : wave_r;
    assign neighbour_osc_o = osc_sel_i ? wave_r : noise_r;
endmodule

// >>> testbench.sv
// Purpose: Self-checking bench for the 16-bit timer/counter.
// Assumes: Register port with one-cycle strobes; read data in the cycle after the strobe.
// Notes:   Random values come from a fixed seed; expectations are worked out here.
`timescale 1ns/1ps
`include "tct_defines.svh"
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module testbench;
    logic                ref_clk_i = 1'b0;
    logic                rst_i     = 1'b1;
    tct_pkg::tct_addr_t  addr_i    = 3'h0;
    tct_pkg::tct_byte_t  wdata_i   = 8'h00;
    logic                wr_i      = 1'b0;
    logic                rd_i      = 1'b0;
    logic                osc_en    = 1'b0;
    logic                trig_req  = 1'b0;
    logic                wave_en   = 1'b0;
    logic                ce        = 1'b1;
    tct_pkg::tct_byte_t  rdata_o;
    tct_pkg::tct_count_t count_o;
    logic [1:0]          tb_sel;
    logic                tb_on;
    logic                irq_o;
    logic                pin;
    logic                osc;
    logic                trig;
    int                  failures = 0;
    int                  checked  = 0;
    int                  cyc      = 0;
    tct_pkg::tct_byte_t  rv;
    tct_pkg::tct_byte_t  hi;
    tct_pkg::tct_byte_t  lo;
    tct_pkg::tct_count_t c0;
    tct_pkg::tct_count_t c1;
    int                  k;

    tct_timer u_tct_timer (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_clk_pin_i(pin),
        .neighbour_osc_i(osc), .neighbour_osc_enable_i(osc_en), .ccp_trigger_i(trig),
        .count_o(count_o), .ccp_timebase_sel_o(tb_sel), .ccp_timebase_o(tb_on), .irq_o(irq_o));

    tct_far_model u_tct_far_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .trig_req_i(trig_req),
        .wave_en_i(wave_en), .osc_sel_i(osc_en), .ext_clk_pin_o(pin), .neighbour_osc_o(osc),
        .ccp_trigger_o(trig));

    initial
    begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // ********************************************************************
    // Bus tasks
    // ********************************************************************
    // A trigger request goes out one cycle early so the pulse meets the write strobe.
    task automatic wr(input tct_pkg::tct_addr_t a, input tct_pkg::tct_byte_t d, input bit trg);
        @(posedge ref_clk_i);
        trig_req <= trg;
        @(posedge ref_clk_i);
        trig_req <= 1'b0;
        wr_i     <= 1'b1;
        addr_i   <= a;
        wdata_i  <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input tct_pkg::tct_addr_t a, output tct_pkg::tct_byte_t d);
        @(posedge ref_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    // ********************************************************************
    // Tests
    // ********************************************************************
    initial
    begin
        void'($urandom(32'h0f6fa1f9));
        step(8);
        rst_i <= 1'b0;
        step(1);
        `CHK("count reset", 16'h0000, count_o)
        for (int a = 0; a < 8; a++)
        begin
            rd(a[2:0], rv);
            `CHK("reset read", 8'h00, rv)
        end
        wr(3'h5, 8'hff, 1'b0);
        rd(3'h5, rv);
        `CHK("unmapped", 8'h00, rv)
        $display("test reset done");

        for (int i = 0; i < 6; i++)
        begin
            hi = (i < 2) ? {i[0], 7'h40} : tct_pkg::tct_byte_t'($urandom);
            wr(`TCT_OFF_CTRL, hi & 8'h7e, 1'b0);
            rd(`TCT_OFF_CTRL, rv);
            `CHK("ctrl", hi & 8'h7e, rv)
            `CHK("tb sel", {hi[6], hi[3]}, tb_sel)
            `CHK("tb on", hi[6], tb_on)
            hi = 8'($urandom);
            lo = 8'($urandom);
            wr(`TCT_OFF_HIGH, hi, 1'b0);
            wr(`TCT_OFF_LOW, lo, 1'b0);
            `CHK("count load", {hi, lo}, count_o)
            rd(`TCT_OFF_HIGH, rv);
            `CHK("high read", hi, rv)
            rd(`TCT_OFF_LOW, rv);
            `CHK("low read", lo, rv)
        end
        $display("test registers done");

        for (int ps = 0; ps < 4; ps++)
        begin
            wr(`TCT_OFF_CTRL, 8'(ps << 4) | (8'($urandom) & 8'h04) | 8'h01, 1'b0);
            step(2);
            c0 = count_o;
            step(32);
            c1 = count_o;
            `CHK("prescale", 16'(32 >> ps), 16'(c1 - c0))
        end
        wr(`TCT_OFF_CTRL, 8'h00, 1'b0);
        c0 = count_o;
        step(16);
        `CHK("frozen", c0, count_o)
        wr(`TCT_OFF_CTRL, 8'h01, 1'b0);
        ce <= 1'b0;
        c0 = count_o;
        step(16);
        `CHK("ce hold", c0, count_o)
        ce <= 1'b1;
        $display("test internal done");

        for (int s = 0; s < 2; s++)
        begin
            k = 1 + ($urandom % 8);
            osc_en <= s[0];
            wr(`TCT_OFF_CTRL, 8'h03 | (8'($urandom) & 8'h04), 1'b0);
            step(6);
            c0 = count_o;
            wave_en <= 1'b1;
            step(8 * k);
            wave_en <= 1'b0;
            step(10);
            `CHK("edges", 16'(k), 16'(count_o - c0))
        end
        $display("test external done");

        wr(`TCT_OFF_CTRL, 8'h00, 1'b0);
        wr(`TCT_OFF_HIGH, 8'hff, 1'b0);
        wr(`TCT_OFF_LOW, 8'hf8, 1'b0);
        wr(`TCT_OFF_STATUS, 8'h01, 1'b0);
        wr(`TCT_OFF_MASK, 8'h01, 1'b0);
        `CHK("no irq yet", 1'b0, irq_o)
        wr(`TCT_OFF_CTRL, 8'h01, 1'b0);
        step(20);
        `CHK("irq", 1'b1, irq_o)
        wr(`TCT_OFF_CTRL, 8'h00, 1'b0);
        rd(`TCT_OFF_STATUS, rv);
        `CHK("flag", 8'h01, rv)
        wr(`TCT_OFF_MASK, 8'h00, 1'b0);
        `CHK("masked", 1'b0, irq_o)
        wr(`TCT_OFF_STATUS, 8'h01, 1'b0);
        rd(`TCT_OFF_STATUS, rv);
        `CHK("flag clear", 8'h00, rv)
        $display("test overflow done");

        wr(`TCT_OFF_MASK, 8'h01, 1'b0);
        wr(`TCT_OFF_HIGH, 8'hff, 1'b0);
        wr(`TCT_OFF_LOW, 8'hff, 1'b0);
        @(posedge ref_clk_i);
        trig_req <= 1'b1;
        @(posedge ref_clk_i);
        trig_req <= 1'b0;
        step(2);
        `CHK("trigger", 16'h0000, count_o)
        rd(`TCT_OFF_STATUS, rv);
        `CHK("trigger flag", 8'h00, rv)
        `CHK("trigger irq", 1'b0, irq_o)
        lo = 8'($urandom);
        wr(`TCT_OFF_HIGH, 8'h77, 1'b0);
        wr(`TCT_OFF_LOW, lo, 1'b1);
        step(1);
        `CHK("write wins", {8'h77, lo}, count_o)
        $display("test trigger done");

        hi = 8'($urandom);
        lo = 8'($urandom);
        wr(`TCT_OFF_CTRL, 8'h80, 1'b0);
        c0 = count_o;
        wr(`TCT_OFF_HIGH, hi, 1'b0);
        `CHK("buffered high", c0, count_o)
        wr(`TCT_OFF_LOW, lo, 1'b0);
        `CHK("atomic load", {hi, lo}, count_o)
        wr(`TCT_OFF_HIGH, ~hi, 1'b0);
        rd(`TCT_OFF_LOW, rv);
        `CHK("wide low", lo, rv)
        @(posedge ref_clk_i);
        trig_req <= 1'b1;
        @(posedge ref_clk_i);
        trig_req <= 1'b0;
        step(2);
        rd(`TCT_OFF_HIGH, rv);
        `CHK("latched high", hi, rv)
        $display("test wide done");
        tally_and_finish();
    end
endmodule
